// ==== hdl/lpmc_apb_regs.sv ====
// APB slave holding the peripheral power control register and a mode status word.
// Assumes a synchronous APB master on core_clk; por_n is the power-on reset only.
`timescale 1ns/10ps
`include "lpmc_map.svh"

module lpmc_apb_regs (
    input  wire logic                     core_clk,
    input  wire logic                     por_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`LPMC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [1:0]               mode_code,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic      [7:0]               pwr_ctrl
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [31:0] rdata;
        logic        err;
    } lpmc_regs_state_t;

    lpmc_regs_state_t state_q;
    lpmc_regs_state_t state_d;

    function automatic logic [1:0] decode(input logic [`LPMC_ADDR_W-1:0] a);
        decode = (a == `LPMC_PWR_CTRL_OFF) ? 2'h1 :
                 (a == `LPMC_MODE_STAT_OFF) ? 2'h2 : 2'h0;
    endfunction

    // Zero wait states: the access phase always completes.
    assign pready   = 1'b1;
    assign prdata   = state_q.rdata;
    assign pslverr  = state_q.err;
    assign pwr_ctrl = state_q.ctrl;

    always_comb begin
        state_d = state_q;
        if (psel && !penable) begin
            state_d.err   = (decode(paddr) == 2'h0);
            state_d.rdata = 32'h0000_0000;
            if (decode(paddr) == 2'h1) begin
                state_d.rdata = {24'h00_0000, state_q.ctrl};
            end else if (decode(paddr) == 2'h2) begin
                state_d.rdata = {30'h0000_0000, mode_code};
            end
        end
        if (psel && penable && pwrite && decode(paddr) == 2'h1) begin
            state_d.ctrl = pwdata[7:0];
        end
    end

    // Only a power-on reset reinitialises the control register. [RL13]
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            state_q <= '{ctrl: `LPMC_PWR_CTRL_RST, rdata: 32'h0000_0000, err: 1'b0}; // [RL13]
        end else begin
            state_q <= state_d;
        end
    end
endmodule

// ==== hdl/lpmc_map.svh ====
// Register map and field positions of the power-mode controller.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH
`define LPMC_PWR_CTRL_OFF   12'hf80
`define LPMC_MODE_STAT_OFF  12'hf84
`define LPMC_PWR_CTRL_RST   8'h80
`define LPMC_BIT_RSV7       7
`define LPMC_BIT_BO_DIS     4
`define LPMC_BIT_ADC_DIS    2
`define LPMC_BIT_CMP_DIS    1
`define LPMC_ADDR_W         12
`endif

// ==== hdl/lpmc_pkg.sv ====
// Types shared by the power-mode controller files.
// Needs no include file; lpmc_map.svh is not used here.
package lpmc_pkg;
    typedef enum logic [1:0] {
        LPMC_ACTIVE,
        LPMC_HALT,
        LPMC_STOP
    } lpmc_mode_t;
endpackage

// ==== hdl/lpmc_top.sv ====
// Power-mode controller: active, halt and stop modes plus peripheral gating.
// Assumes the core pulses stop_instr_done or halt_instr_done when the instruction retires.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "lpmc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RL1 - Stop instruction enters stop; all peripherals off but brown-out and watchdog
// RL2 - Stop halts crystal and precision oscillators and frees crystal pins to GPIO
// RL3 - Stop freezes system clock, core and program counter
// RL4 - Stop keeps watchdog oscillator and watchdog running when enabled
// RL5 - Brown-out runs in stop only if its stop option bit is set
// RL6 - Stop idles every other peripheral
// RL7 - Stop is left only by stop mode recovery
// RL8 - Halt instruction stops core and counter; oscillator and clock keep running
// RL9 - Halt keeps watchdog and all other peripherals running
// RL10 - Halt exits on interrupt, watchdog time-out, power-on, brown-out or reset pin
// RL11 - Active mode when neither stop nor halt; peripherals may be disabled
// RL12 - Each disable bit gates its peripheral clock or power
// RL13 - Power control register is reset only by power-on reset
// RL14 - Software writes bit 7 one, bits 6:5, 3 and 0 zero
// RL15 - Bit 4 disables brown-out; both it and always-on option must enable
// RL16 - Bit 2 disables the ADC
// RL17 - Bit 1 disables the comparator
// RL18 - Mode entry only after the stop or halt instruction completes
module lpmc_top (
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    input  wire logic                     por_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`LPMC_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     stop_instr_done,
    input  wire logic                     halt_instr_done,
    input  wire logic                     stop_recovery,
    input  wire logic                     irq_pending,
    input  wire logic                     wdt_timeout,
    input  wire logic                     brownout_reset,
    input  wire logic                     ext_reset_pin,
    input  wire logic                     wdt_osc_enable,
    input  wire logic                     wdt_enable,
    input  wire logic                     brownout_always_on_option,
    input  wire logic                     brownout_stop_option,
    input  wire logic                     crystal_enable,
    output logic      [1:0]               mode_code,
    output logic                          main_osc_run,
    output logic                          sys_clk_run,
    output logic                          core_run,
    output logic                          program_counter_hold,
    output logic                          crystal_pins_release,
    output logic                          wdt_osc_run,
    output logic                          wdt_run,
    output logic                          brownout_run,
    output logic                          adc_clk_en,
    output logic                          cmp_clk_en,
    output logic                          periph_clk_en
);
    typedef struct packed {
        lpmc_pkg::lpmc_mode_t mode;
        logic                 main_osc;
        logic                 sys_clk;
        logic                 core;
        logic                 pc_hold;
        logic                 xtal_rel;
        logic                 wdt_osc;
        logic                 wdt;
        logic                 bo;
        logic                 adc;
        logic                 cmp;
        logic                 periph;
    } lpmc_state_t;

    lpmc_state_t state_q;
    lpmc_state_t state_d;
    logic [7:0]  pwr_ctrl;
    lpmc_pkg::lpmc_mode_t nmode;

    lpmc_apb_regs u_regs (
        .core_clk  (core_clk),
        .por_n     (por_n),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .mode_code (state_q.mode),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .pwr_ctrl  (pwr_ctrl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencing and enables
    always_comb begin
        nmode = state_q.mode;
        unique case (state_q.mode)
            lpmc_pkg::LPMC_ACTIVE: begin
                // Retire pulse marks a finished instruction, so nothing is cut short [RL18]
                if (stop_instr_done) begin
                    nmode = lpmc_pkg::LPMC_STOP; // [RL1]
                end else if (halt_instr_done) begin
                    nmode = lpmc_pkg::LPMC_HALT; // [RL8]
                end
            end
            lpmc_pkg::LPMC_HALT: begin
                if (irq_pending || wdt_timeout || brownout_reset || ext_reset_pin) begin
                    nmode = lpmc_pkg::LPMC_ACTIVE; // [RL10]
                end
            end
            lpmc_pkg::LPMC_STOP: begin
                if (stop_recovery) begin
                    nmode = lpmc_pkg::LPMC_ACTIVE; // [RL7]
                end
            end
            default: nmode = lpmc_pkg::LPMC_ACTIVE;
        endcase
        state_d.mode     = nmode;
        // Stop freezes oscillators, clock and core; halt only the core [RL2] [RL3] [RL8]
        state_d.main_osc = (nmode != lpmc_pkg::LPMC_STOP);
        state_d.sys_clk  = (nmode != lpmc_pkg::LPMC_STOP);
        state_d.core     = (nmode == lpmc_pkg::LPMC_ACTIVE); // [RL11]
        state_d.pc_hold  = (nmode != lpmc_pkg::LPMC_ACTIVE); // [RL3]
        state_d.xtal_rel = (nmode == lpmc_pkg::LPMC_STOP) || !crystal_enable; // [RL2]
        // Watchdog survives both low-power modes [RL4] [RL9]
        state_d.wdt_osc  = wdt_osc_enable || (nmode == lpmc_pkg::LPMC_HALT);
        state_d.wdt      = wdt_enable;
        // Brown-out needs register and option; stop also needs its own option [RL5] [RL15]
        state_d.bo       = !pwr_ctrl[`LPMC_BIT_BO_DIS] && brownout_always_on_option
                           && ((nmode != lpmc_pkg::LPMC_STOP) || brownout_stop_option);
        // ADC and comparator clock gates from disable bits, all idle in stop [RL6] [RL12]
        state_d.adc      = !pwr_ctrl[`LPMC_BIT_ADC_DIS] && (nmode != lpmc_pkg::LPMC_STOP); // [RL16]
        state_d.cmp      = !pwr_ctrl[`LPMC_BIT_CMP_DIS] && (nmode != lpmc_pkg::LPMC_STOP); // [RL17]
        state_d.periph   = (nmode != lpmc_pkg::LPMC_STOP); // [RL9]
    end

    // Any system reset returns to active; the control register keeps its value on reset_n, but por_n reloads it
    always_ff @(posedge core_clk) begin
        if (!reset_n || !por_n) begin
            state_q <= '{mode: lpmc_pkg::LPMC_ACTIVE, main_osc: 1'b1, sys_clk: 1'b1,
                         core: 1'b1, pc_hold: 1'b0, xtal_rel: 1'b1, wdt_osc: 1'b0,
                         wdt: 1'b0, bo: 1'b0, adc: 1'b0, cmp: 1'b0, periph: 1'b1};
        end else begin
            state_q <= state_d;
        end
    end

    assign mode_code            = state_q.mode;
    assign main_osc_run         = state_q.main_osc;
    assign sys_clk_run          = state_q.sys_clk;
    assign core_run             = state_q.core;
    assign program_counter_hold = state_q.pc_hold;
    assign crystal_pins_release = state_q.xtal_rel;
    assign wdt_osc_run          = state_q.wdt_osc;
    assign wdt_run              = state_q.wdt;
    assign brownout_run         = state_q.bo;
    assign adc_clk_en           = state_q.adc;
    assign cmp_clk_en           = state_q.cmp;
    assign periph_clk_en        = state_q.periph;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    stop_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL1]
        state_q.mode == lpmc_pkg::LPMC_ACTIVE && stop_instr_done
        |=> state_q.mode == lpmc_pkg::LPMC_STOP)
        else $error("Stop not entered");
    stop_clocks_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL3]
        state_q.mode == lpmc_pkg::LPMC_STOP |-> !sys_clk_run && !main_osc_run
        && !core_run && program_counter_hold)
        else $error("Clocks run in stop");
    stop_xtal_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL2]
        state_q.mode == lpmc_pkg::LPMC_STOP |-> crystal_pins_release)
        else $error("Crystal pins held in stop");
    stop_exit_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL7]
        state_q.mode == lpmc_pkg::LPMC_STOP && !stop_recovery
        |=> state_q.mode == lpmc_pkg::LPMC_STOP)
        else $error("Stop left without recovery");
    stop_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL6]
        state_q.mode == lpmc_pkg::LPMC_STOP |-> !adc_clk_en && !cmp_clk_en && !periph_clk_en)
        else $error("Peripheral active in stop");
    halt_entry_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL8]
        state_q.mode == lpmc_pkg::LPMC_ACTIVE && halt_instr_done && !stop_instr_done
        |=> state_q.mode == lpmc_pkg::LPMC_HALT && sys_clk_run && !core_run)
        else $error("Halt not entered");
    halt_exit_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL10]
        state_q.mode == lpmc_pkg::LPMC_HALT && irq_pending
        |=> state_q.mode == lpmc_pkg::LPMC_ACTIVE ##0 core_run)
        else $error("Halt not left on wake");
    adc_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL16]
        $past(pwr_ctrl[`LPMC_BIT_ADC_DIS]) |-> !adc_clk_en)
        else $error("ADC clock runs while disabled");
    bo_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n || !por_n) // [RL15]
        brownout_run |-> !$past(pwr_ctrl[`LPMC_BIT_BO_DIS]) && $past(brownout_always_on_option))
        else $error("Brown-out on while disabled");
endmodule

// ==== testbench/lpmc_core_model.sv ====
// Behavioural model of the processor core that retires stop and halt instructions.
// Assumes retire is called by the bench just after a rising edge of core_clk.
`timescale 1ns/10ps

module lpmc_core_model (
    input  wire logic core_clk,
    output logic      stop_instr_done,
    output logic      halt_instr_done
);
    initial begin
        stop_instr_done = 1'h0;
        halt_instr_done = 1'h0;
    end

    // The pulse comes only once the instruction has retired, one cycle wide
    task automatic retire(input logic is_stop);
        @(posedge core_clk);
        stop_instr_done <= is_stop;
        halt_instr_done <= !is_stop;
        @(posedge core_clk);
        stop_instr_done <= 1'h0;
        halt_instr_done <= 1'h0;
    endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the power-mode controller, APB master and core model.
// Assumes lpmc_map.svh on the include path; the APB task waits on pready, so wait states are tolerated.
`timescale 1ns/10ps
`include "lpmc_map.svh"

module tb;
    logic        core_clk, reset_n, por_n, psel, penable, pwrite, stop_rec, crystal_enable;
    logic        wosc_en, wdt_en, bo_ao, bo_stop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  wake;
    logic [1:0]  mode_code;
    logic        pready, pslverr, err, stop_d, halt_d, main_o, sys_c, core_r, pc_h, xrel;
    logic        wosc_r, wdt_r, bo_r, adc_e, cmp_e, per_e;
    int          n_errors, tests_run;
    wire  [8:0]  st = {main_o, sys_c, core_r, pc_h, xrel, wosc_r, wdt_r, bo_r, per_e};

    lpmc_core_model u_core (.core_clk(core_clk), .stop_instr_done(stop_d),
        .halt_instr_done(halt_d));
    lpmc_top u_dut (.core_clk(core_clk), .reset_n(reset_n), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_instr_done(stop_d), .halt_instr_done(halt_d),
        .stop_recovery(stop_rec), .irq_pending(wake[0]), .wdt_timeout(wake[1]),
        .brownout_reset(wake[2]), .ext_reset_pin(wake[3]), .wdt_osc_enable(wosc_en),
        .wdt_enable(wdt_en), .brownout_always_on_option(bo_ao),
        .brownout_stop_option(bo_stop), .crystal_enable(crystal_enable),
        .mode_code(mode_code), .main_osc_run(main_o), .sys_clk_run(sys_c), .core_run(core_r),
        .program_counter_hold(pc_h), .crystal_pins_release(xrel), .wdt_osc_run(wosc_r),
        .wdt_run(wdt_r), .brownout_run(bo_r), .adc_clk_en(adc_e), .cmp_clk_en(cmp_e),
        .periph_clk_en(per_e));

    always #5 core_clk = !core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Request held until pready is seen high; data taken at that edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        // No cycle count assumed; only the watchdog ends a hung access
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask

    task automatic wait_mode(input logic [1:0] m);
        int i;
        for (i = 0; i < 6 && mode_code !== m; i++) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        chk(mode_code, m);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_ctrl();
        int b;
        apb(1'h0, `LPMC_PWR_CTRL_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        for (b = 1; b <= 4; b++) begin
            if (b == 3) continue;
            apb(1'h1, `LPMC_PWR_CTRL_OFF, 32'h0000_0080 | (32'h0000_0001 << b));
            repeat (3) @(posedge core_clk);
            chk({bo_r, adc_e, cmp_e}, {b != 4, b != 2, b != 1});
        end
        apb(1'h1, `LPMC_PWR_CTRL_OFF, 32'h0000_0080);
        bo_ao <= 1'h0;
        repeat (3) @(posedge core_clk);
        chk({bo_r, adc_e, cmp_e}, 32'h0000_0003);
        bo_ao <= 1'h1;
    endtask

    // Option pins toggled together so both stop variants are seen
    task automatic t_stop();
        int o;
        for (o = 0; o < 2; o++) begin
            {bo_stop, wosc_en, wdt_en} <= {3{o[0]}};
            repeat (3) @(posedge core_clk);
            chk(mode_code, 32'h0000_0000);
            u_core.retire(1'h1);
            wait_mode(2'h2);
            chk(st, {5'h03, {3{o[0]}}, 1'h0});
            wake <= 4'hf;
            repeat (3) @(posedge core_clk);
            chk(mode_code, 32'h0000_0002);
            wake <= 4'h0;
            stop_rec <= 1'h1;
            @(posedge core_clk);
            stop_rec <= 1'h0;
            wait_mode(2'h0);
        end
    endtask

    task automatic t_halt();
        int i;
        for (i = 0; i < 4; i++) begin
            u_core.retire(1'h0);
            wait_mode(2'h1);
            chk(st, 32'h0000_01af);
            apb(1'h0, `LPMC_MODE_STAT_OFF, 32'h0000_0000);
            chk(rd, 32'h0000_0001);
            wake <= 4'h1 << i;
            @(posedge core_clk);
            wake <= 4'h0;
            wait_mode(2'h0);
            chk(st, 32'h0000_01cf);
        end
    endtask

    task automatic t_keep();
        apb(1'h1, `LPMC_MODE_STAT_OFF, 32'h0000_0003);
        apb(1'h0, 12'hf88, 32'h0000_0000);
        chk({err, rd}, 33'h1_0000_0000);
        apb(1'h1, `LPMC_PWR_CTRL_OFF, 32'h0000_0096);
        reset_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'h1;
        apb(1'h0, `LPMC_PWR_CTRL_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0096);
        chk(mode_code, 32'h0000_0000);
        por_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        por_n <= 1'h1;
        apb(1'h0, `LPMC_PWR_CTRL_OFF, 32'h0000_0000);
        chk(rd, 32'h0000_0080);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {core_clk, reset_n, por_n, psel, penable, pwrite, stop_rec} = 7'h00;
        {wosc_en, wdt_en, bo_ao, bo_stop, crystal_enable} = 5'h1f;
        {paddr, pwdata, wake} = 48'h0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'h1;
        por_n <= 1'h1;
        repeat (3) @(posedge core_clk);
        t_ctrl();
        t_stop();
        t_halt();
        t_keep();
        results();
    end

    initial begin
        #200000;
        n_errors++;
        results();
    end
endmodule
